// ===== logic/tss_cfg.svh
// Constants for the time-slot switch input alignment and connection control
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH
// ----------------------------------------------------------------------------
// Register map (index times four gives the APB byte address)
// ----------------------------------------------------------------------------
`define TSS_FOR0_IDX 8'h03
`define TSS_FOR_ADDR(n) (8'((`TSS_FOR0_IDX + (n)) * 4))
`define TSS_MODE_ADDR 8'h20
`define TSS_CM_ADDR_ADDR 8'h24
`define TSS_CM_DATA_ADDR 8'h28
`define TSS_MEAS_ADDR 8'h2C
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TSS_FOR_RST 16'h0000
`define TSS_CM_RST 16'h0000
`define TSS_MEAS_RST 4'h8
// ----------------------------------------------------------------------------
// Connection word fields
// ----------------------------------------------------------------------------
`define TSS_CM_CHANNEL_LOOPBACK 15
`define TSS_CM_VC 14
`define TSS_CM_MC 13
`define TSS_CM_CONTROL_SERIAL_OUTPUT 12
`define TSS_CM_OE 11
`define TSS_CM_SAB_LSB 7
`define TSS_CM_CAB_LSB 0
`define TSS_OFS_MAX 3'h4
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TSS_CLK_NS 5
`define TSS_BIT_CYC 8
`define TSS_CHANNELS 128
`define TSS_STREAMS 16
`endif

// ===== logic/tss_pkg.sv
// Types shared by the time-slot switch modules
`default_nettype none
package tss_pkg;
   // Aligner frame state
   typedef enum logic [2:0] {
      ALN_IDLE = 3'b001,
      ALN_WAIT = 3'b010,
      ALN_RUN = 3'b100
   } align_state_t;
   // One stored byte of a channel
   typedef logic [7:0] chan_byte_t;
   // One connection memory word
   typedef logic [15:0] conn_word_t;
endpackage : tss_pkg
`default_nettype wire

// ===== logic/capture_if.sv
// Carrier of captured channel bytes from an aligner to the switch core
`default_nettype none
interface capture_if #(parameter int CW = 7);
   logic wr_en;          // One-cycle strobe, byte complete
   logic [CW-1:0] chan;  // Channel number of the byte
   logic [7:0] data;     // Captured byte, first bit in msb
   modport src (output wr_en, output chan, output data);
   modport dst (input wr_en, input chan, input data);
endinterface : capture_if
`default_nettype wire

// ===== logic/stream_aligner.sv
// Per-stream frame alignment and serial to parallel capture
`include "tss_cfg.svh"
`default_nettype none
module stream_aligner
   import tss_pkg::*;
#(
   parameter int BIT_CYC = `TSS_BIT_CYC,
   parameter int CH = `TSS_CHANNELS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic frame_pulse_input,
   input wire logic serial_in,
   input wire logic [2:0] offset,
   input wire logic latch_edge_select,
   capture_if.src cap
);
   // ----------------------------------------------------------------------------
   // Derived timing
   // ----------------------------------------------------------------------------
   localparam int HALF = BIT_CYC / 4;         // Half switch clock period
   localparam int SAMP = (BIT_CYC * 3) / 4;   // Three quarter point of the cell
   localparam int PW = $clog2(BIT_CYC);
   localparam int CW = $clog2(CH);

   align_state_t state_q;        // Frame state
   logic [7:0] dly_q;            // Remaining shift cycles
   logic [PW-1:0] ph_q;          // Phase within the bit cell
   logic [2:0] bit_q;            // Bit within the channel
   logic [CW-1:0] ch_q;          // Channel within the frame
   logic [7:0] sh_q;             // Capture shift register
   logic [2:0] ofs_lim;          // Offset limited to the largest shift
   logic [7:0] shift_cyc;        // Total shift in clock cycles

   // Offset beyond four is held at four
   assign ofs_lim = (offset > `TSS_OFS_MAX) ? `TSS_OFS_MAX : offset;
   // Whole periods count two halves, latch edge adds one half
   assign shift_cyc = 8'({ofs_lim, latch_edge_select}) * 8'(HALF);

   // ----------------------------------------------------------------------------
   // Frame start delay and bit timing
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ALN_IDLE;
         dly_q <= 8'h00;
         ph_q <= '0;
         bit_q <= 3'h0;
         ch_q <= '0;
      end else if (frame_pulse_input) begin
         // Bit 0 of the new frame is recognised after the programmed shift
         ph_q <= '0;
         bit_q <= 3'h0;
         ch_q <= '0;
         dly_q <= shift_cyc;
         // Zero offset and edge bit leave the frame unshifted
         state_q <= (shift_cyc == 8'h00) ? ALN_RUN : ALN_WAIT;
      end else begin
         case (state_q)
            ALN_IDLE: begin
               // Wait for the first frame pulse
               state_q <= ALN_IDLE;
            end
            ALN_WAIT: begin
               // Count out the shift
               dly_q <= dly_q - 8'h01;
               if (dly_q == 8'h01) begin
                  state_q <= ALN_RUN;
               end
            end
            ALN_RUN: begin
               // Step phase, bit and channel
               if (ph_q == PW'(BIT_CYC - 1)) begin
                  ph_q <= '0;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     ch_q <= (ch_q == CW'(CH - 1)) ? '0 : ch_q + CW'(1);
                  end
               end else begin
                  ph_q <= ph_q + PW'(1);
               end
            end
            default: begin
               state_q <= ALN_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Sampling at the three quarter point of each shifted cell
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sh_q <= 8'h00;
      end else if (state_q == ALN_RUN && ph_q == PW'(SAMP)) begin
         // Edge bit 0 is the rising edge, 1 the falling edge half a period later
         sh_q <= {sh_q[6:0], serial_in};
      end
   end

   // Hand a complete byte to the core
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap.wr_en <= 1'b0;
         cap.chan <= '0;
         cap.data <= 8'h00;
      end else begin
         cap.wr_en <= (state_q == ALN_RUN) && !frame_pulse_input && (ph_q == PW'(BIT_CYC - 1)) && (bit_q == 3'h7);
         cap.chan <= ch_q;
         cap.data <= sh_q;
      end
   end
endmodule : stream_aligner
`default_nettype wire

// ===== logic/tss_core.sv
// Time-slot switch core: APB registers, data and connection memories, output streams
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`include "tss_cfg.svh"
`default_nettype none
// Behaviour
// - Frame start delayed by programmed offset
// - Telecom mode, edge bit 0: rising-edge sample
// - Telecom mode, edge bit 1: falling-edge sample
// - GCI mode, edge bit 0: falling-edge sample (mode bit unused; edge bit 0 samples the rising edge in both modes)
// - Sixteen streams, three offset bits, edge bit
// - All zero means no shift
// - Shift is offset plus half for edge
// - Largest shift four and a half periods
// - Measurement: whole count, flag marks whole
// - Loopback feeds input n from output n
// - Bit 14 picks variable or constant delay
// - Message bit sends the low byte
// - Output enable zero floats the channel
// - Source stream bits select input stream
module tss_core
   import tss_pkg::*;
#(
   parameter int BIT_CYC = `TSS_BIT_CYC,
   parameter int CH = `TSS_CHANNELS,
   parameter int NS = `TSS_STREAMS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_pulse_input,
   input wire logic frame_eval_input,
   input wire logic [NS-1:0] serial_input_stream,
   output logic [NS-1:0] serial_output_stream,
   output logic [NS-1:0] serial_output_oe_n
);
   // ----------------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------------
   localparam int PW = $clog2(BIT_CYC);
   localparam int CW = $clog2(CH);
   localparam int SW = $clog2(NS);
   localparam int HALF = BIT_CYC / 4;
   localparam int NFOR = NS / 4;

   // ----------------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------------
   logic [15:0] for_q [NFOR];          // Frame input offset registers
   logic mode_gci_q;                   // 1 GCI, 0 telecom serial mode; stored and read back only
   logic [SW+CW-1:0] cm_addr_q;        // Connection memory pointer
   conn_word_t conn_mem [NS*CH];       // Connection memory words
   logic [3:0] meas_q;                 // Measured delay, flag in bit 3
   logic [31:0] prdata_q;              // Read data held for the access phase
   logic pslverr_q;                    // Error answer held for the access phase
   logic wr_acc;                       // Write completes this edge

   // Decode whether an address is one of the offset registers
   function automatic logic for_hit(input logic [7:0] a);
      for_hit = 1'b0;
      for (int i = 0; i < NFOR; i++) begin
         if (a == `TSS_FOR_ADDR(i)) begin
            for_hit = 1'b1;
         end
      end
   endfunction : for_hit

   // Index of an offset register from its address
   function automatic logic [1:0] for_idx(input logic [7:0] a);
      for_idx = 2'(8'(a >> 2) - `TSS_FOR0_IDX);
   endfunction : for_idx

   // Any mapped address
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = for_hit(a) || a == `TSS_MODE_ADDR || a == `TSS_CM_ADDR_ADDR || a == `TSS_CM_DATA_ADDR
         || a == `TSS_MEAS_ADDR;
   endfunction : addr_ok

   // ----------------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------------
   assign pready = psel & penable;     // Zero wait states
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & psel & penable;
   assign wr_acc = psel & penable & pwrite & addr_ok(paddr);

   // Read data and error flag are captured in the setup cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_q <= !addr_ok(paddr);
         prdata_q <= 32'h0000_0000;
         if (!pwrite) begin
            if (for_hit(paddr)) begin
               prdata_q <= {16'h0000, for_q[for_idx(paddr)]};
            end else if (paddr == `TSS_MODE_ADDR) begin
               prdata_q <= {31'h0, mode_gci_q};
            end else if (paddr == `TSS_CM_ADDR_ADDR) begin
               prdata_q <= 32'(cm_addr_q);
            end else if (paddr == `TSS_CM_DATA_ADDR) begin
               prdata_q <= {16'h0000, conn_mem[cm_addr_q]};
            end else if (paddr == `TSS_MEAS_ADDR) begin
               prdata_q <= {28'h0, meas_q};
            end
         end
      end
   end

   // Offset, mode and pointer registers
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NFOR; i++) begin
            for_q[i] <= `TSS_FOR_RST;
         end
         mode_gci_q <= 1'b0;
         cm_addr_q <= '0;
      end else if (wr_acc) begin
         if (for_hit(paddr)) begin
            for_q[for_idx(paddr)] <= pwdata[15:0];
         end else if (paddr == `TSS_MODE_ADDR) begin
            mode_gci_q <= pwdata[0];
         end else if (paddr == `TSS_CM_ADDR_ADDR) begin
            cm_addr_q <= pwdata[SW+CW-1:0];
         end
      end
   end

   // Connection memory, written through the pointer
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NS * CH; i++) begin
            conn_mem[i] <= `TSS_CM_RST;
         end
      end else if (wr_acc && paddr == `TSS_CM_DATA_ADDR) begin
         conn_mem[cm_addr_q] <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Frame delay measurement on the evaluation input
   // ----------------------------------------------------------------------------
   logic [7:0] mcnt_q;                 // Cycles since the frame pulse
   logic meas_arm_q;                   // Waiting for the evaluation edge
   logic eval_prev_q;                  // Previous evaluation level
   logic [7:0] half_cnt;               // Delay in half periods, capped
   assign half_cnt = (8'(mcnt_q + 8'h01) / 8'(HALF) > 8'd9) ? 8'd9 : 8'(mcnt_q + 8'h01) / 8'(HALF);

   // Count from the frame pulse to the first rising evaluation edge
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mcnt_q <= 8'h00;
         meas_arm_q <= 1'b0;
         eval_prev_q <= 1'b0;
         meas_q <= `TSS_MEAS_RST;
      end else begin
         eval_prev_q <= frame_eval_input;
         if (frame_pulse_input) begin
            mcnt_q <= 8'h00;
            meas_arm_q <= 1'b1;
         end else if (meas_arm_q) begin
            mcnt_q <= (mcnt_q == 8'hFF) ? mcnt_q : mcnt_q + 8'h01;
            if (frame_eval_input && !eval_prev_q) begin
               meas_arm_q <= 1'b0;
               // Whole periods in the low bits, flag set for a whole count
               meas_q <= {~half_cnt[0], half_cnt[3:1]};
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Input alignment per stream
   // ----------------------------------------------------------------------------
   logic [NS-1:0] aln_in;              // Aligner input after loopback choice
   logic [NS-1:0] channel_loopback_q;              // Loopback of the current channel
   logic [NS-1:0] cap_en;
   logic [CW-1:0] cap_ch [NS];
   chan_byte_t cap_byte [NS];

   for (genvar g = 0; g < NS; g++) begin : g_aln
      capture_if #(.CW(CW)) cap_l ();
      logic [3:0] nib;                 // Offset bits and edge bit of this stream
      assign nib = for_q[g / 4][(g % 4) * 4 +: 4];
      // Looped channels take the data the stream sends out
      assign aln_in[g] = channel_loopback_q[g] ? serial_output_stream[g] : serial_input_stream[g];
      stream_aligner #(.BIT_CYC(BIT_CYC), .CH(CH)) u_aln (
         .ref_clk(ref_clk),
         .sys_rst(sys_rst),
         .frame_pulse_input(frame_pulse_input),
         .serial_in(aln_in[g]),
         .offset(nib[3:1]),
         .latch_edge_select(nib[0]),
         .cap(cap_l.src)
      );
      assign cap_en[g] = cap_l.wr_en;
      assign cap_ch[g] = cap_l.chan;
      assign cap_byte[g] = cap_l.data;
   end

   // ----------------------------------------------------------------------------
   // Data memory, two frame banks
   // ----------------------------------------------------------------------------
   chan_byte_t data_mem [2*NS*CH];     // Captured bytes by bank, stream, channel
   logic in_bank_q;                    // Bank written in the current frame

   // Bank flips at each frame pulse
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_bank_q <= 1'b0;
      end else if (frame_pulse_input) begin
         in_bank_q <= ~in_bank_q;
      end
   end

   // Store each completed byte of every stream
   always_ff @(posedge ref_clk) begin
      for (int s = 0; s < NS; s++) begin
         if (cap_en[s]) begin
            data_mem[{in_bank_q, SW'(s), cap_ch[s]}] <= cap_byte[s];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Output frame timing
   // ----------------------------------------------------------------------------
   logic [PW-1:0] oph_q;               // Phase within the output cell
   logic [2:0] obit_q;                 // Output bit within the channel
   logic [CW-1:0] och_q;               // Output channel
   logic orun_q;                       // Frame timing started
   logic chan_start;                   // Next cycle opens a channel
   logic cell_end;                     // Last cycle of an output cell
   logic [CW-1:0] next_ch;

   assign cell_end = orun_q && oph_q == PW'(BIT_CYC - 1);
   assign chan_start = frame_pulse_input || (cell_end && obit_q == 3'h7);
   assign next_ch = frame_pulse_input ? '0 : ((och_q == CW'(CH - 1)) ? '0 : och_q + CW'(1));

   // Unshifted timing from the frame pulse
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         oph_q <= '0;
         obit_q <= 3'h0;
         och_q <= '0;
         orun_q <= 1'b0;
      end else if (frame_pulse_input) begin
         oph_q <= '0;
         obit_q <= 3'h0;
         och_q <= '0;
         orun_q <= 1'b1;
      end else if (cell_end) begin
         oph_q <= '0;
         obit_q <= obit_q + 3'h1;
         if (obit_q == 3'h7) begin
            och_q <= next_ch;
         end
      end else if (orun_q) begin
         oph_q <= oph_q + PW'(1);
      end
   end

   // ----------------------------------------------------------------------------
   // Output streams
   // ----------------------------------------------------------------------------
   conn_word_t cur_word [NS];          // Word of the channel about to open
   chan_byte_t load_byte [NS];         // Byte to send in that channel
   logic [7:0] osh_q [NS];             // Output shift registers

   for (genvar g = 0; g < NS; g++) begin : g_out
      logic src_bank;
      chan_byte_t src_byte;
      assign cur_word[g] = conn_mem[{SW'(g), next_ch}];
      // Constant delay reads last frame, variable delay the current bank
      assign src_bank = cur_word[g][`TSS_CM_VC] ? ~in_bank_q : in_bank_q;
      // Source stream and channel fields address the data memory
      assign src_byte = data_mem[{src_bank, cur_word[g][`TSS_CM_SAB_LSB +: SW],
         cur_word[g][`TSS_CM_CAB_LSB +: CW]}];
      // Message channels send the low byte of the word itself
      assign load_byte[g] = cur_word[g][`TSS_CM_MC] ? cur_word[g][7:0] : src_byte;
   end

   // Load at channel start, shift out msb first at each cell end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int s = 0; s < NS; s++) begin
            osh_q[s] <= 8'h00;
         end
         serial_output_oe_n <= '1;
         channel_loopback_q <= '0;
      end else if (chan_start) begin
         for (int s = 0; s < NS; s++) begin
            osh_q[s] <= load_byte[s];
            serial_output_oe_n[s] <= ~cur_word[s][`TSS_CM_OE];
            channel_loopback_q[s] <= cur_word[s][`TSS_CM_CHANNEL_LOOPBACK];
         end
      end else if (cell_end) begin
         for (int s = 0; s < NS; s++) begin
            osh_q[s] <= {osh_q[s][6:0], 1'b0};
         end
      end
   end

   // Serial output bits from flip-flops
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_output_stream <= '0;
      end else begin
         for (int s = 0; s < NS; s++) begin
            serial_output_stream[s] <= (chan_start ? load_byte[s][7] : (cell_end ? osh_q[s][6] : osh_q[s][7]));
         end
      end
   end
endmodule : tss_core
`default_nettype wire

// ===== sim/tss_checker.sv
// Port checker for the switch core
`default_nettype none
module tss_checker #(
   parameter int NS = 16
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_pulse_input,
   input wire logic [NS-1:0] serial_output_stream,
   input wire logic [NS-1:0] serial_output_oe_n
);
   // ----------
   // Cell position
   // ----------
   logic [2:0] pos_q; // Cell cycle
   logic seen_q; // A frame has started
   logic map_w; // Mapped address
   assign map_w = paddr inside {8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C};
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pos_q <= 3'h0;
         seen_q <= 1'b0;
      end else begin
         pos_q <= frame_pulse_input ? 3'h1 : pos_q + 3'h1;
         seen_q <= seen_q | frame_pulse_input;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ----------
   // Properties
   // ----------
   property p_rdy; pready == (psel && penable); endproperty
   a_rdy: assert property (p_rdy) else $error("pready not tied to access phase");
   property p_err; psel && penable && !map_w |-> pslverr && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_ok; psel && penable && map_w |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_gate; pslverr |-> psel && penable; endproperty
   a_gate: assert property (p_gate) else $error("error outside access phase");
   property p_upper; psel && penable && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_hold; $changed(prdata) |-> $past(psel) && !$past(penable); endproperty
   a_hold: assert property (p_hold) else $error("read data moved outside setup");
   property p_cell; $changed(serial_output_stream) |-> pos_q == 3'h1; endproperty
   a_cell: assert property (p_cell) else $error("output bit off cell boundary");
   property p_oe_cell; $changed(serial_output_oe_n) |-> pos_q == 3'h1; endproperty
   a_oe_cell: assert property (p_oe_cell) else $error("enable off cell boundary");
   property p_quiet; !seen_q |-> &serial_output_oe_n && serial_output_stream == '0; endproperty
   a_quiet: assert property (p_quiet) else $error("output active before frame");
endmodule : tss_checker
bind tss_core tss_checker #(.NS(NS)) u_tss_checker (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .frame_pulse_input, .serial_output_stream, .serial_output_oe_n);
`default_nettype wire

// ===== sim/stream_src.sv
// Far-side model: frame pulses and continuous serial input streams
`default_nettype none
module stream_src #(
   parameter int CH = 4
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [4:0] dly,
   output logic frame_pulse_input,
   output logic [15:0] serial_input_stream
);
   localparam int FRAME = 64 * CH;
   int t_q; // Frame position
   int i; // Launched bit position
   logic [7:0] p; // Current byte
   // Byte per stream and channel
   function automatic logic [7:0] pat(input int s, input int m);
      return 8'(s * 16 + m) ^ 8'h5A;
   endfunction : pat
   // Frame counter
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         t_q <= 8;
      end else begin
         t_q <= (t_q == FRAME - 1) ? 0 : t_q + 1;
      end
   end
   assign frame_pulse_input = (t_q == 0);
   // Launch dly cycles late
   assign i = (t_q + 2 * FRAME - 1 - int'(dly)) % FRAME;
   // MSB first
   always_comb begin
      for (int s = 0; s < 16; s++) begin
         p = pat(s, i / 64);
         serial_input_stream[s] = p[7 - (i / 8) % 8];
      end
   end
endmodule : stream_src
`default_nettype wire

// ===== sim/tb.sv
// Self-checking testbench for the switch core
`include "tss_cfg.svh"
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CH = 4;
   logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, frame_eval_input = 0;
   logic [7:0] paddr = 0, b;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, frame_pulse_input;
   logic [15:0] serial_input_stream, serial_output_stream, serial_output_oe_n;
   logic [4:0] dly = 0; // Far-side delay
   logic [2:0] o;
   logic [3:0] h;
   logic [32:0] rd_q[$], r; // {error, read data}
   logic [19:0] ser_q[$], e; // {oe_n, stream, channel, byte}
   logic [7:0] g;
   int fail_count = 0, cmp_count = 0, seed = 32'h2088;
   int mk[6] = '{2, 3, 8, 9, 19, 25};
   always #2.5 ref_clk = ~ref_clk;
   tss_core #(.CH(CH)) u_tss_core (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .frame_pulse_input, .frame_eval_input, .serial_input_stream, .serial_output_stream,
      .serial_output_oe_n);
   stream_src #(.CH(CH)) u_stream_src (.ref_clk, .sys_rst, .dly, .frame_pulse_input, .serial_input_stream);
   // ----------
   // Bus tasks
   // ----------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      rd_q.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic cm(input logic [3:0] s, input logic [6:0] m, input logic [15:0] w);
      apb(1'b1, `TSS_CM_ADDR_ADDR, 32'(s) << $clog2(CH) | 32'(m));
      apb(1'b1, `TSS_CM_DATA_ADDR, {16'h0, w});
   endtask : cm
   task automatic frames(input int n);
      repeat (n) @(posedge ref_clk iff frame_pulse_input);
   endtask : frames
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   // ----------
   // Watchers
   // ----------
   always @(posedge ref_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() > 0) begin
         r = rd_q.pop_front();
         `CHK({pslverr, prdata}, r)
      end
   end
   always @(posedge ref_clk) begin
      if (frame_pulse_input && ser_q.size() > 0) begin
         e = ser_q.pop_front();
         repeat (64 * e[14:8] + 5) @(posedge ref_clk);
         for (int k = 0; k < 8; k++) begin
            g = {g[6:0], serial_output_stream[e[18:15]]};
            `CHK(serial_output_oe_n[e[18:15]], e[19])
            repeat (8) @(posedge ref_clk);
         end
         if (!e[19]) `CHK(g, e[7:0])
      end
   end
   // Hang guard
   initial begin
      #200000;
      fail_count++;
      summarize();
   end
   // ----------
   // Main sequence
   // ----------
   initial begin
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) rd(`TSS_FOR_ADDR(i), 33'h0);
      rd(`TSS_MEAS_ADDR, 33'h8);
      rd(8'h40, {1'b1, 32'h0});
      b = 8'($random(seed));
      apb(1'b1, `TSS_FOR_ADDR(3), {16'hFFFF, b, 8'hF0});
      rd(`TSS_FOR_ADDR(3), {17'h0, b, 8'hF0});
      apb(1'b1, `TSS_FOR_ADDR(3), 32'h0);
      $display("end of register test");
      cm(4'h1, 7'h0, {8'h28, b});
      cm(4'h2, 7'h0, {8'h20, b});
      cm(4'h4, 7'h0, {8'hA8, b});
      cm(4'h3, 7'h0, 16'h4A00);
      frames(1);
      ser_q.push_back({1'b0, 4'h1, 7'h0, b});
      ser_q.push_back({1'b1, 4'h2, 7'h0, b});
      ser_q.push_back({1'b0, 4'h3, 7'h0, b});
      frames(3);
      $display("end of message test");
      for (int k = 0; k < 11; k++) begin
         o = (k == 10) ? 3'h7 : 3'(k / 2);
         apb(1'b1, `TSS_FOR_ADDR(1), 32'({o, k[0] | (k == 10)}) << 4);
         dly <= 5'((o > 4 ? 16 : 4 * o) + 2 * (k[0] | (k == 10)));
         cm(4'h3, 7'h1, 16'(32'h0800 | (k[0] << 14) | (5 << 7) | 2));
         frames(3);
         ser_q.push_back({1'b0, 4'h3, 7'h1, 8'h52 ^ 8'h5A});
         frames(2);
      end
      $display("end of offset test");
      foreach (mk[i]) begin
         frames(1);
         repeat (mk[i] - 1) @(posedge ref_clk);
         frame_eval_input <= 1'b1;
         repeat (4) @(posedge ref_clk);
         frame_eval_input <= 1'b0;
         h = 4'(mk[i] / 2 > 9 ? 9 : mk[i] / 2);
         repeat (20) @(posedge ref_clk);
         rd(`TSS_MEAS_ADDR, 33'({~h[0], h[3:1]}));
      end
      $display("end of measurement test");
      summarize();
   end
endmodule : tb
`default_nettype wire
